// file: common/rbat_pkg.sv
// Shared constants and carrier types for the register bit access bank.
`default_nettype none

package rbat_pkg;

    // ************************************************************
    // Sizes and register indices
    // ************************************************************
    localparam int NREG = 11;
    localparam int DW = 8;
    localparam int AW = 4;

    typedef logic [DW-1:0] rbat_data_t;
    typedef logic [AW-1:0] rbat_addr_t;
    typedef logic [NREG-1:0] rbat_hit_t;
    typedef logic [NREG-1:0][DW-1:0] rbat_bank_t;

    localparam rbat_addr_t IDX_RO = 4'h0;
    localparam rbat_addr_t IDX_RDSET = 4'h1;
    localparam rbat_addr_t IDX_RC = 4'h2;
    localparam rbat_addr_t IDX_WO = 4'h3;
    localparam rbat_addr_t IDX_WC = 4'h4;
    localparam rbat_addr_t IDX_WANY = 4'h5;
    localparam rbat_addr_t IDX_LATLO = 4'h6;
    localparam rbat_addr_t IDX_LATHI = 4'h7;
    localparam rbat_addr_t IDX_SCLR = 4'h8;
    localparam rbat_addr_t IDX_SS = 4'h9;
    localparam rbat_addr_t IDX_PHY = 4'ha;
    localparam rbat_addr_t IDX_LAST = 4'ha;

    // ************************************************************
    // Data constants, reset values and reset exemption masks
    // ************************************************************
    localparam rbat_data_t DATA_ZERO = 8'h00;
    localparam rbat_data_t DATA_ONES = 8'hff;

    // Entries run from index 10 on the left down to index 0 on the right.
    localparam rbat_bank_t RST_VAL = {
        8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };
    localparam rbat_bank_t KEEP_LITE = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h0f, 8'h00
    };
    localparam rbat_bank_t KEEP_SOFT = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00
    };

    // ************************************************************
    // Carrier structs
    // ************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        rbat_addr_t addr;
        rbat_data_t wdata;
    } rbat_req_s;

    typedef struct packed {
        rbat_data_t ro_val;
        rbat_data_t rc_set;
        rbat_data_t wc_set;
        rbat_data_t wac_set;
        rbat_data_t ll_cond;
        rbat_data_t lh_cond;
        rbat_data_t phy_cond;
    } rbat_hw_s;

    typedef struct packed {
        rbat_data_t wo_ctl;
        rbat_data_t read_sets_bit;
        rbat_data_t self_clearing;
        rbat_data_t self_setting;
    } rbat_ctl_s;

endpackage

`default_nettype wire

// file: rtl/rbat_bank.sv
// Register bank with one register for each bit access type.
`default_nettype none

// Summary of operation
// - Read-only register ignores writes, reads current value.
// - Read-to-set bits become one on read.
// - Read-to-clear returns contents then clears; writes ignored.
// - Write-only accepts writes; reads return zero.
// - Write one clears bit; zero leaves it.
// - Any write clears write-any-clears register.
// - Latch-low holds until register read clears.
// - Latch-high holds until register read clears.
// - Self-clearing bit returns to zero by itself.
// - Self-setting bit returns to one by itself.
// - PHY latched-high holds until read, then follows.
// - Lite-reset-exempt bits keep state on lite reset.
// - Soft-reset-exempt bits keep state on soft reset.
module rbat_bank (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic lite_rst,
    input wire logic soft_rst,
    input wire rbat_pkg::rbat_req_s host_req,
    input wire rbat_pkg::rbat_hw_s hw_in,
    output logic [rbat_pkg::DW-1:0] rdata,
    output logic rvalid,
    output rbat_pkg::rbat_ctl_s ctl_out
);

    // ************************************************************
    // State
    // ************************************************************
    rbat_pkg::rbat_bank_t bank_r;
    rbat_pkg::rbat_bank_t bank_nxt;
    rbat_pkg::rbat_bank_t raw;
    rbat_pkg::rbat_data_t armed_r;
    rbat_pkg::rbat_data_t armed_nxt;
    rbat_pkg::rbat_data_t rdata_r;
    rbat_pkg::rbat_data_t rdata_nxt;
    rbat_pkg::rbat_data_t rd_mask;
    rbat_pkg::rbat_data_t keep;
    logic rvalid_r;
    logic rvalid_nxt;
    rbat_pkg::rbat_hit_t rd_hit;
    rbat_pkg::rbat_hit_t wr_hit;

    // ************************************************************
    // Address decode
    // ************************************************************

    // One read strobe and one write strobe per register entry.
    genvar gi;
    generate
        for (gi = 0; gi < rbat_pkg::NREG; gi++) begin : g_dec
            assign rd_hit[gi] = host_req.rd && (host_req.addr == rbat_pkg::rbat_addr_t'(gi));
            assign wr_hit[gi] = host_req.wr && (host_req.addr == rbat_pkg::rbat_addr_t'(gi));
        end
    endgenerate

    // ************************************************************
    // Next values of the access primitives
    // ************************************************************

    // Each entry applies its own read and write side effects; hardware sets win.
    always_comb begin
        raw = bank_r;
        rd_mask = rd_hit[rbat_pkg::IDX_PHY] ? rbat_pkg::DATA_ONES : rbat_pkg::DATA_ZERO;
        // Status copy that writes never reach.
        raw[rbat_pkg::IDX_RO] = hw_in.ro_val;
        // A read sets all bits and takes priority over a write.
        if (rd_hit[rbat_pkg::IDX_RDSET]) begin
            raw[rbat_pkg::IDX_RDSET] = rbat_pkg::DATA_ONES;
        end else if (wr_hit[rbat_pkg::IDX_RDSET]) begin
            raw[rbat_pkg::IDX_RDSET] = host_req.wdata;
        end
        // Read clears, writes ignored, a new event in the read cycle is kept.
        if (rd_hit[rbat_pkg::IDX_RC]) begin
            raw[rbat_pkg::IDX_RC] = hw_in.rc_set;
        end else begin
            raw[rbat_pkg::IDX_RC] = bank_r[rbat_pkg::IDX_RC] | hw_in.rc_set;
        end
        // Write-only control value.
        if (wr_hit[rbat_pkg::IDX_WO]) begin
            raw[rbat_pkg::IDX_WO] = host_req.wdata;
        end
        // Ones in the write data clear, zeros leave bits alone.
        if (wr_hit[rbat_pkg::IDX_WC]) begin
            raw[rbat_pkg::IDX_WC] = (bank_r[rbat_pkg::IDX_WC] & ~host_req.wdata)
                | hw_in.wc_set;
        end else begin
            raw[rbat_pkg::IDX_WC] = bank_r[rbat_pkg::IDX_WC] | hw_in.wc_set;
        end
        // Any write clears the whole entry whatever the data.
        if (wr_hit[rbat_pkg::IDX_WANY]) begin
            raw[rbat_pkg::IDX_WANY] = hw_in.wac_set;
        end else begin
            raw[rbat_pkg::IDX_WANY] = bank_r[rbat_pkg::IDX_WANY] | hw_in.wac_set;
        end
        // Latch low holds a zero until a read releases it to the live level.
        if (rd_hit[rbat_pkg::IDX_LATLO]) begin
            raw[rbat_pkg::IDX_LATLO] = hw_in.ll_cond;
        end else begin
            raw[rbat_pkg::IDX_LATLO] = bank_r[rbat_pkg::IDX_LATLO] & hw_in.ll_cond;
        end
        // Latch high holds a one until a read releases it to the live level.
        if (rd_hit[rbat_pkg::IDX_LATHI]) begin
            raw[rbat_pkg::IDX_LATHI] = hw_in.lh_cond;
        end else begin
            raw[rbat_pkg::IDX_LATHI] = bank_r[rbat_pkg::IDX_LATHI] | hw_in.lh_cond;
        end
        // Written ones stand for one cycle, then clear themselves.
        raw[rbat_pkg::IDX_SCLR] = wr_hit[rbat_pkg::IDX_SCLR] ? host_req.wdata
            : rbat_pkg::DATA_ZERO;
        // Written zeros stand for one cycle, then set themselves.
        raw[rbat_pkg::IDX_SS] = wr_hit[rbat_pkg::IDX_SS] ? host_req.wdata
            : rbat_pkg::DATA_ONES;
        // Unread bits hold high; read bits follow the condition.
        raw[rbat_pkg::IDX_PHY] = hw_in.phy_cond
            | (bank_r[rbat_pkg::IDX_PHY] & ~(armed_r | rd_mask));
    end

    // Lite and soft resets restore the non-exempt bits of every entry.
    always_comb begin
        bank_nxt = raw;
        keep = rbat_pkg::DATA_ONES;
        for (int i = 0; i < rbat_pkg::NREG; i++) begin
            keep = (lite_rst ? rbat_pkg::KEEP_LITE[i] : rbat_pkg::DATA_ONES)
                & (soft_rst ? rbat_pkg::KEEP_SOFT[i] : rbat_pkg::DATA_ONES);
            bank_nxt[i] = (raw[i] & keep) | (rbat_pkg::RST_VAL[i] & ~keep);
        end
    end

    // Read tracking for the PHY latch; cleared when the bit falls or on any reset.
    always_comb begin
        armed_nxt = (armed_r | rd_mask) & raw[rbat_pkg::IDX_PHY];
        if (lite_rst || soft_rst) begin
            armed_nxt = rbat_pkg::DATA_ZERO;
        end
    end

    // ************************************************************
    // Read data path
    // ************************************************************

    // Read data shows the contents before the read side effect.
    always_comb begin
        rvalid_nxt = host_req.rd;
        rdata_nxt = rdata_r;
        if (host_req.rd) begin
            if (host_req.addr > rbat_pkg::IDX_LAST || host_req.addr == rbat_pkg::IDX_WO) begin
                rdata_nxt = rbat_pkg::DATA_ZERO;
            end else begin
                rdata_nxt = bank_r[host_req.addr];
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Hard reset loads the defined reset values.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bank_r <= rbat_pkg::RST_VAL;
            armed_r <= rbat_pkg::DATA_ZERO;
            rdata_r <= rbat_pkg::DATA_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            bank_r <= bank_nxt;
            armed_r <= armed_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Outputs come straight from flip-flops: the read data and flag registers and the bank.
    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign ctl_out.wo_ctl = bank_r[rbat_pkg::IDX_WO];
    assign ctl_out.read_sets_bit = bank_r[rbat_pkg::IDX_RDSET];
    assign ctl_out.self_clearing = bank_r[rbat_pkg::IDX_SCLR];
    assign ctl_out.self_setting = bank_r[rbat_pkg::IDX_SS];

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic no_rst;
    assign no_rst = !lite_rst && !soft_rst;

    // A write of ones to the self-clearing entry with no write right after.
    sequence s_sclr_pulse;
        wr_hit[rbat_pkg::IDX_SCLR] && host_req.wdata != rbat_pkg::DATA_ZERO && no_rst
            ##1 !wr_hit[rbat_pkg::IDX_SCLR] && no_rst;
    endsequence

    // A write of zeros to the self-setting entry with no write right after.
    sequence s_ss_pulse;
        wr_hit[rbat_pkg::IDX_SS] && host_req.wdata != 8'hff && no_rst
            ##1 !wr_hit[rbat_pkg::IDX_SS] && no_rst;
    endsequence

    AST_RO_TRACKS: assert property (
        no_rst |=> bank_r[rbat_pkg::IDX_RO] == $past(hw_in.ro_val))
        else $error("Read-only entry does not track its status.");

    AST_RDSET_ON_READ: assert property (
        rd_hit[rbat_pkg::IDX_RDSET] && no_rst
            |=> bank_r[rbat_pkg::IDX_RDSET] == rbat_pkg::DATA_ONES)
        else $error("Read-to-set entry not set by read.");

    AST_RC_CLEAR: assert property (
        rd_hit[rbat_pkg::IDX_RC] && hw_in.rc_set == 8'h00 && no_rst
            |=> rdata == $past(bank_r[rbat_pkg::IDX_RC]) && bank_r[rbat_pkg::IDX_RC] == 8'h00)
        else $error("Read-to-clear entry returned wrong data or did not clear.");

    AST_WO_STORE: assert property (
        wr_hit[rbat_pkg::IDX_WO] && no_rst |=> ctl_out.wo_ctl == $past(host_req.wdata))
        else $error("Write-only entry did not take the write.");

    AST_WC_CLEAR: assert property (
        wr_hit[rbat_pkg::IDX_WC] && hw_in.wc_set == 8'h00 && no_rst
            |=> bank_r[rbat_pkg::IDX_WC] == ($past(bank_r[rbat_pkg::IDX_WC])
                & ~$past(host_req.wdata)))
        else $error("Write-one-to-clear entry wrong after write.");

    AST_WANY_CLEAR: assert property (
        wr_hit[rbat_pkg::IDX_WANY] && hw_in.wac_set == rbat_pkg::DATA_ZERO && no_rst
            |=> bank_r[rbat_pkg::IDX_WANY] == rbat_pkg::DATA_ZERO)
        else $error("Write-anything-to-clear entry not cleared.");

    AST_LATLO_HOLD: assert property (
        !rd_hit[rbat_pkg::IDX_LATLO] && no_rst |=> bank_r[rbat_pkg::IDX_LATLO]
            == ($past(bank_r[rbat_pkg::IDX_LATLO]) & $past(hw_in.ll_cond)))
        else $error("Latch-low entry lost its latched zero.");

    AST_LATHI_HOLD: assert property (
        !rd_hit[rbat_pkg::IDX_LATHI] && no_rst |=> bank_r[rbat_pkg::IDX_LATHI]
            == ($past(bank_r[rbat_pkg::IDX_LATHI]) | $past(hw_in.lh_cond)))
        else $error("Latch-high entry lost its latched one.");

    // A read releases the latch-low entry to the live condition.
    AST_LATLO_READ: assert property (
        rd_hit[rbat_pkg::IDX_LATLO] && no_rst
            |=> bank_r[rbat_pkg::IDX_LATLO] == $past(hw_in.ll_cond))
        else $error("Latch-low entry not released by a read.");

    // A read releases the latch-high entry to the live condition.
    AST_LATHI_READ: assert property (
        rd_hit[rbat_pkg::IDX_LATHI] && no_rst
            |=> bank_r[rbat_pkg::IDX_LATHI] == $past(hw_in.lh_cond))
        else $error("Latch-high entry not released by a read.");

    AST_SCLR_SELF_CLEAR: assert property (
        s_sclr_pulse |-> ctl_out.self_clearing == $past(host_req.wdata) ##1
            ctl_out.self_clearing == rbat_pkg::DATA_ZERO)
        else $error("Self-clearing entry did not clear itself.");

    AST_SS_SELF_SET: assert property (
        s_ss_pulse |-> ctl_out.self_setting == $past(host_req.wdata) ##1
            ctl_out.self_setting == 8'hff)
        else $error("Self-setting entry did not set itself.");

    AST_PHY_HOLD: assert property (
        !rd_hit[rbat_pkg::IDX_PHY] && no_rst |=> (bank_r[rbat_pkg::IDX_PHY]
            & $past(bank_r[rbat_pkg::IDX_PHY] & ~armed_r))
            == $past(bank_r[rbat_pkg::IDX_PHY] & ~armed_r))
        else $error("Unread PHY latched bit dropped.");

    AST_PHY_FOLLOW: assert property (
        rd_hit[rbat_pkg::IDX_PHY] && no_rst ##1 no_rst
            |=> bank_r[rbat_pkg::IDX_PHY] == $past(hw_in.phy_cond))
        else $error("Read PHY latched bit does not follow its condition.");

    AST_LITE_KEEP: assert property (
        lite_rst && !soft_rst && !wr_hit[rbat_pkg::IDX_WO]
            |=> (ctl_out.wo_ctl & 8'hf0) == ($past(ctl_out.wo_ctl) & 8'hf0)
                && (ctl_out.wo_ctl & 8'h0f) == 8'h00)
        else $error("Lite reset changed an exempt bit or missed another.");

    AST_SOFT_KEEP: assert property (
        soft_rst && !lite_rst && !wr_hit[rbat_pkg::IDX_WO]
            |=> (ctl_out.wo_ctl & 8'hc0) == ($past(ctl_out.wo_ctl) & 8'hc0)
                && (ctl_out.wo_ctl & 8'h3f) == 8'h00)
        else $error("Soft reset changed an exempt bit or missed another.");

    AST_RESET_VALUES: assert property (
        (lite_rst || soft_rst) && hw_in.wc_set == 8'h00
            |=> bank_r[rbat_pkg::IDX_WC] == 8'h00 && ctl_out.self_setting == 8'hff
                && armed_r == 8'h00)
        else $error("Reset did not restore defined values.");

    // The read answer flag stands in the cycle right after each read.
    AST_READ_VALID: assert property (
        1'b1 |=> rvalid == $past(host_req.rd))
        else $error("Read valid flag does not follow the read strobe.");

    // Read data holds its last value while no read is made.
    AST_RDATA_HOLD: assert property (
        !host_req.rd |=> rdata == $past(rdata))
        else $error("Read data changed without a read.");

    // A write to the read-to-clear entry leaves it as hardware sets it.
    AST_RC_WRITE_IGNORED: assert property (
        wr_hit[rbat_pkg::IDX_RC] && !rd_hit[rbat_pkg::IDX_RC] && no_rst
            |=> bank_r[rbat_pkg::IDX_RC] == ($past(bank_r[rbat_pkg::IDX_RC])
                | $past(hw_in.rc_set)))
        else $error("Write changed the read-to-clear entry.");

endmodule

`default_nettype wire

// file: verif/tb.sv
// Self-checking random testbench for the register bit access bank.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Signals and bench state
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic lite_rst = 1'b0;
    logic soft_rst = 1'b0;
    rbat_pkg::rbat_req_s req = '0;
    rbat_pkg::rbat_hw_s hw = '0;
    rbat_pkg::rbat_hw_s hw_nxt = '0;
    logic [rbat_pkg::DW-1:0] rdata;
    logic rvalid;
    rbat_pkg::rbat_ctl_s ctl;
    int seed = 32'h2344;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc_count = 0;
    rbat_pkg::rbat_bank_t mdl = rbat_pkg::RST_VAL;
    rbat_pkg::rbat_data_t armed = 8'h00;
    rbat_pkg::rbat_data_t exp_rdata = 8'h00;
    logic exp_rvalid = 1'b0;
    logic rd_known = 1'b1;

    // The clock toggles every half period of 2 ns.
    always #2 clk_sys = ~clk_sys;

    rbat_bank dut (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lite_rst(lite_rst),
        .soft_rst(soft_rst),
        .host_req(req),
        .hw_in(hw),
        .rdata(rdata),
        .rvalid(rvalid),
        .ctl_out(ctl)
    );

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input rbat_pkg::rbat_data_t seen, input rbat_pkg::rbat_data_t exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A hung run is cut off well past the expected length of about 3100 cycles.
    always @(posedge clk_sys) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Reference model of every entry, advanced once per edge
    // ************************************************************
    function automatic void model_edge();
        rbat_pkg::rbat_bank_t n;
        rbat_pkg::rbat_data_t rm;
        rbat_pkg::rbat_data_t keep;
        logic [15:0] rh;
        logic [15:0] wh;
        rh = req.rd ? (16'h0001 << req.addr) : 16'h0000;
        wh = req.wr ? (16'h0001 << req.addr) : 16'h0000;
        n = mdl;
        exp_rvalid = req.rd;
        if (req.rd) begin
            rd_known = (req.addr <= rbat_pkg::IDX_LAST) && (req.addr != rbat_pkg::IDX_WO);
            exp_rdata = rd_known ? mdl[req.addr] : 8'h00;
        end
        n[0] = hw.ro_val;
        n[1] = rh[1] ? 8'hff : (wh[1] ? req.wdata : mdl[1]);
        n[2] = rh[2] ? hw.rc_set : (mdl[2] | hw.rc_set);
        n[3] = wh[3] ? req.wdata : mdl[3];
        n[4] = (wh[4] ? (mdl[4] & ~req.wdata) : mdl[4]) | hw.wc_set;
        n[5] = wh[5] ? hw.wac_set : (mdl[5] | hw.wac_set);
        n[6] = rh[6] ? hw.ll_cond : (mdl[6] & hw.ll_cond);
        n[7] = rh[7] ? hw.lh_cond : (mdl[7] | hw.lh_cond);
        n[8] = wh[8] ? req.wdata : 8'h00;
        n[9] = wh[9] ? req.wdata : 8'hff;
        rm = rh[10] ? 8'hff : 8'h00;
        n[10] = hw.phy_cond | (mdl[10] & ~(armed | rm));
        armed = (armed | rm) & n[10];
        // Lite and soft resets pull every bit outside the keep masks back to its reset value.
        if (lite_rst || soft_rst) begin
            for (int i = 0; i < rbat_pkg::NREG; i++) begin
                keep = (lite_rst ? rbat_pkg::KEEP_LITE[i] : 8'hff)
                    & (soft_rst ? rbat_pkg::KEEP_SOFT[i] : 8'hff);
                n[i] = (n[i] & keep) | (rbat_pkg::RST_VAL[i] & ~keep);
            end
            armed = 8'h00;
        end
        mdl = n;
    endfunction

    task automatic compare_all();
        chk({7'h00, rvalid}, {7'h00, exp_rvalid});
        if (rd_known) chk(rdata, exp_rdata);
        chk(ctl.wo_ctl, mdl[3]);
        chk(ctl.read_sets_bit, mdl[1]);
        chk(ctl.self_clearing, mdl[8]);
        chk(ctl.self_setting, mdl[9]);
    endtask

    // ************************************************************
    // Drivers
    // ************************************************************
    task automatic cyc(input logic rd, input logic wr, input rbat_pkg::rbat_addr_t a,
                       input rbat_pkg::rbat_data_t wd, input logic lr, input logic sr);
        @(posedge clk_sys);
        if (rstn) model_edge();
        req <= '{rd: rd, wr: wr, addr: a, wdata: wd};
        hw <= hw_nxt;
        lite_rst <= lr;
        soft_rst <= sr;
        #1;
        compare_all();
    endtask

    // The hard reset lands after this edge's update, then holds for four cycles.
    task automatic apply_reset();
        @(posedge clk_sys);
        if (rstn) model_edge();
        rstn <= 1'b0;
        req <= '0;
        lite_rst <= 1'b0;
        soft_rst <= 1'b0;
        #1;
        mdl = rbat_pkg::RST_VAL;
        armed = 8'h00;
        exp_rdata = 8'h00;
        exp_rvalid = 1'b0;
        rd_known = 1'b1;
        compare_all();
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask

    // Random traffic on addresses 0 to 10, no reads while a lite or soft reset is applied.
    task automatic rand_cyc();
        logic [31:0] r;
        logic lr;
        logic sr;
        hw_nxt.ro_val = rbat_pkg::rbat_data_t'($random(seed));
        hw_nxt.rc_set = rbat_pkg::rbat_data_t'($random(seed) & $random(seed) & $random(seed));
        hw_nxt.wc_set = rbat_pkg::rbat_data_t'($random(seed) & $random(seed) & $random(seed));
        hw_nxt.wac_set = rbat_pkg::rbat_data_t'($random(seed) & $random(seed) & $random(seed));
        if (($random(seed) & 7) == 0) begin
            hw_nxt.ll_cond = rbat_pkg::rbat_data_t'($random(seed) | $random(seed));
        end
        if (($random(seed) & 7) == 0) begin
            hw_nxt.lh_cond = rbat_pkg::rbat_data_t'($random(seed) & $random(seed));
        end
        if (($random(seed) & 3) == 0) begin
            hw_nxt.phy_cond = rbat_pkg::rbat_data_t'($random(seed) & $random(seed));
        end
        // Every entry is fully defined, so no write data lands in a reserved field.
        r = $random(seed);
        lr = (r[31:26] == 6'h00) || (r[31:26] == 6'h02);
        sr = (r[31:26] == 6'h01) || (r[31:26] == 6'h02);
        cyc(r[0] && !(lr || sr), r[1], rbat_pkg::rbat_addr_t'(r[15:8] % 8'h0b),
            r[23:16], lr, sr);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        apply_reset();
        hw_nxt.rc_set = 8'h81;
        hw_nxt.wc_set = 8'h81;
        hw_nxt.wac_set = 8'h81;
        hw_nxt.lh_cond = 8'h81;
        hw_nxt.phy_cond = 8'h81;
        hw_nxt.ll_cond = 8'h7e;
        cyc(1'b0, 1'b1, 4'h0, 8'hff, 1'b0, 1'b0);
        hw_nxt = '0;
        hw_nxt.ro_val = 8'h5a;
        hw_nxt.ll_cond = 8'hff;
        cyc(1'b1, 1'b1, 4'h1, 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h2, 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h4, 8'h01, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h5, 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h8, 8'h01, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h9, 8'hfe, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'hf, 8'hff, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 4'h3, 8'hff, 1'b0, 1'b0);
        cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b1, 1'b0);
        cyc(1'b0, 1'b1, 4'h3, 8'hff, 1'b0, 1'b1);
        cyc(1'b0, 1'b1, 4'h3, 8'hff, 1'b1, 1'b1);
        // Every address read twice back to back, the unmapped ones among them.
        for (int i = 0; i < 32; i++) begin
            cyc(1'b1, 1'b0, rbat_pkg::rbat_addr_t'(i / 2), 8'h00, 1'b0, 1'b0);
        end
        repeat (2) begin
            repeat (1500) rand_cyc();
            apply_reset();
        end
        repeat (4) cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
